// ==== inc/ptg_pkg.sv ====
/*
 Constants, field positions and types shared by the panel timing
 generator. Assumes a 32-bit APB bus and a separate pixel link clock.
*/
// What this block does
// - Pixel clock 33.3 MHz, panel samples falling
// - Exactly 800 visible pixels every active line
// - Horizontal sync low for 8 clocks
// - 38 clocks horizontal back porch, no data
// - 210 clocks horizontal front porch, enable low
// - 480 active lines in every frame
// - Vertical sync low one line per frame
// - 22 lines vertical back porch
// - 22 lines vertical front porch
// - Sync mode plus active-high data enable
// - 16-bit RGB pixels from 16bpp data
package ptg_pkg;

   // Nominal pixel clock, in kHz (33.3 MHz)
   localparam int PIX_CLK_KHZ = 33300;

   // Horizontal settings, in pixel clocks
   localparam logic [10:0] HSYNC_WIDTH_SETTING   = 11'h008; // 8
   localparam logic [10:0] H_BACK_PORCH_SETTING  = 11'h026; // 38
   localparam logic [10:0] ACTIVE_WIDTH_SETTING  = 11'h320; // 800
   localparam logic [10:0] H_FRONT_PORCH_SETTING = 11'h0D2; // 210
   localparam logic [10:0] H_ACT_START = HSYNC_WIDTH_SETTING
                                       + H_BACK_PORCH_SETTING;
   localparam logic [10:0] H_ACT_END   = H_ACT_START
                                       + ACTIVE_WIDTH_SETTING;
   localparam logic [10:0] H_TOTAL     = H_ACT_END
                                       + H_FRONT_PORCH_SETTING;

   // Vertical settings, in line periods
   localparam logic [9:0] VSYNC_WIDTH_SETTING   = 10'h001; // 1
   localparam logic [9:0] V_BACK_PORCH_SETTING  = 10'h016; // 22
   localparam logic [9:0] ACTIVE_HEIGHT_SETTING = 10'h1E0; // 480
   localparam logic [9:0] V_FRONT_PORCH_SETTING = 10'h016; // 22
   localparam logic [9:0] V_ACT_START = VSYNC_WIDTH_SETTING
                                      + V_BACK_PORCH_SETTING;
   localparam logic [9:0] V_ACT_END   = V_ACT_START
                                      + ACTIVE_HEIGHT_SETTING;
   localparam logic [9:0] V_TOTAL     = V_ACT_END
                                      + V_FRONT_PORCH_SETTING;

   // Pixel word width (RGB 5:6:5)
   localparam int PIX_W = 16;

   // Register byte addresses
   localparam logic [11:0] ADDR_CTRL   = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam logic [11:0] ADDR_FRAMES = 12'h008;

   // Field positions
   localparam int CTRL_EN_BIT     = 0;
   localparam int CTRL_BLANK_BIT  = 1;
   localparam int STAT_RUN_BIT    = 0;
   localparam int STAT_VBLANK_BIT = 1;

   // Reset values
   localparam logic [1:0]  CTRL_RESET  = 2'h0;
   localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;
   localparam logic [15:0] FRAMES_ZERO = 16'h0000;

   // Link-side run control
   typedef enum logic [1:0] {
      PTG_IDLE   = 2'b01,
      PTG_ACTIVE = 2'b10
   } ptg_run_e;

endpackage

// ==== logic/ptg_sync.sv ====
/*
 Two-flop level synchroniser of configurable width.
 Assumes each bit is a level that stays put for several clocks.
*/
`timescale 1ns/1ps
module ptg_sync #(
   parameter int W = 1
) (
   // Destination clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Asynchronous input and synchronised output
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta; // First stage, read only by the second

   // Only q may be used downstream; meta can be metastable
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end

endmodule

// ==== logic/ptg_top.sv ====
/*
 Panel timing generator: APB register slave on pclk, raster counters
 and panel outputs on the pixel link clock.
 Assumes link_clk is the 33.3 MHz pixel clock, and that the pixel
 source sits on link_clk and answers pixel_req in the same cycle.
*/
`timescale 1ns/1ps
module ptg_top
   import ptg_pkg::*;
(
   // APB slave
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [11:0]      paddr,
   input  wire logic [31:0]      pwdata,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   // Pixel link clock
   input  wire logic             link_clk,
   // Pixel source
   input  wire logic [PIX_W-1:0] pixel_in,
   output logic                  pixel_req,
   output logic                  frame_start,
   // Panel
   output logic                  pixel_clock,
   output logic                  hsync_n,
   output logic                  vsync_n,
   output logic                  de,
   output logic      [PIX_W-1:0] rgb
);

   // pclk domain state
   logic [1:0]  ctrl;        // Enable and blank bits
   logic [2:0]  stat_p;      // Run, vblank, frame toggle in pclk
   logic        tgl_seen;    // Previous frame toggle
   logic [15:0] frames;      // Frames started since reset
   logic        apb_acc;     // Access phase, not yet answered
   logic        apb_done;    // Access phase completing now

   // Link domain state
   logic        lrst_n;      // Reset released on link_clk
   logic [1:0]  ctrl_l;      // Control bits seen on link_clk
   ptg_run_e    run_st;      // Idle or producing frames
   logic [10:0] h_cnt;       // Pixel position in line
   logic [9:0]  v_cnt;       // Line position in frame
   logic        hs1;         // Sync pipeline stage one
   logic        vs1;
   logic        frm_tgl;     // Flips at each frame start
   logic        run_l;       // Status: frames running
   logic        vblank_l;    // Status: outside active lines

   // Stage-zero decode of the counters
   logic        running;
   logic        h_act;
   logic        v_act;
   logic        act0;
   logic        line_end;
   logic        frame_end;

   // APB: one wait state, answer registered
   assign apb_acc  = psel & penable & ~pready;
   assign apb_done = psel & penable & pready;

   // Ready rises one edge into the access phase, then drops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= apb_acc;
      end
   end

   // Read data and error are computed with ready and held with it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= WORD_ZERO;
         pslverr <= 1'b0;
      end else if (apb_acc) begin
         prdata  <= WORD_ZERO;
         pslverr <= 1'b0;
         unique case (paddr)
            ADDR_CTRL: begin
               prdata[1:0] <= ctrl;
            end
            ADDR_STATUS: begin
               prdata[STAT_RUN_BIT]    <= stat_p[0];
               prdata[STAT_VBLANK_BIT] <= stat_p[1];
            end
            ADDR_FRAMES: begin
               prdata[15:0] <= frames;
            end
            default: begin
               // Unmapped: error, data zero
               pslverr <= 1'b1;
            end
         endcase
      end
   end

   // Control register; takes effect only on the completing edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= CTRL_RESET;
      end else if (apb_done && pwrite && paddr == ADDR_CTRL) begin
         ctrl[0] <= pwdata[CTRL_EN_BIT];
         ctrl[1] <= pwdata[CTRL_BLANK_BIT];
      end
   end

   // Status levels and frame toggle brought into pclk
   ptg_sync #(
      .W (3)
   ) u_stat_sync (
      .clk   (pclk),
      .rst_n (presetn),
      .d     ({frm_tgl, vblank_l, run_l}),
      .q     (stat_p)
   );

   // Frame counter; each toggle edge is one frame start
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tgl_seen <= 1'b0;
         frames   <= FRAMES_ZERO;
      end else begin
         tgl_seen <= stat_p[2];
         if (stat_p[2] != tgl_seen) begin
            frames <= frames + 16'h0001;
         end
      end
   end

   // Link reset: asserted at once, released in step with link_clk
   ptg_sync #(
      .W (1)
   ) u_rst_sync (
      .clk   (link_clk),
      .rst_n (presetn),
      .d     (1'b1),
      .q     (lrst_n)
   );

   // Control bits into the link domain; quasi-static levels
   ptg_sync #(
      .W (2)
   ) u_ctrl_sync (
      .clk   (link_clk),
      .rst_n (lrst_n),
      .d     (ctrl),
      .q     (ctrl_l)
   );

   // Forwarded pixel clock. Outputs launch on the rising edge so they
   // are half a period settled when the panel samples on the fall.
   assign pixel_clock = link_clk;

   // Stage-zero decode
   assign running   = (run_st == PTG_ACTIVE);
   assign line_end  = (h_cnt == H_TOTAL - 11'h001);
   assign frame_end = line_end && (v_cnt == V_TOTAL - 10'h001);
   assign h_act     = (h_cnt >= H_ACT_START) && (h_cnt < H_ACT_END);
   assign v_act     = (v_cnt >= V_ACT_START) && (v_cnt < V_ACT_END);
   assign act0      = running && h_act && v_act;

   // Run control; stopping waits for the frame end so the panel
   // never sees a truncated frame
   always_ff @(posedge link_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         run_st <= PTG_IDLE;
      end else begin
         unique case (run_st)
            PTG_IDLE: begin
               if (ctrl_l[0]) begin
                  run_st <= PTG_ACTIVE;
               end
            end
            PTG_ACTIVE: begin
               if (frame_end && !ctrl_l[0]) begin
                  run_st <= PTG_IDLE;
               end
            end
         endcase
      end
   end

   // Raster counters: line is sync, back porch, active, front porch
   always_ff @(posedge link_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         h_cnt <= 11'h000;
         v_cnt <= 10'h000;
      end else if (!running) begin
         h_cnt <= 11'h000;
         v_cnt <= 10'h000;
      end else if (line_end) begin
         h_cnt <= 11'h000;
         if (frame_end) begin
            v_cnt <= 10'h000;
         end else begin
            v_cnt <= v_cnt + 10'h001;
         end
      end else begin
         h_cnt <= h_cnt + 11'h001;
      end
   end

   // Stage one: request the pixel, stage the sync levels
   always_ff @(posedge link_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         pixel_req   <= 1'b0;
         hs1         <= 1'b0;
         vs1         <= 1'b0;
         frame_start <= 1'b0;
         frm_tgl     <= 1'b0;
      end else begin
         pixel_req   <= act0;
         hs1         <= running && (h_cnt < HSYNC_WIDTH_SETTING);
         vs1         <= running && (v_cnt < VSYNC_WIDTH_SETTING);
         frame_start <= running && h_cnt == 11'h000 && v_cnt == 10'h000;
         if (running && h_cnt == 11'h000 && v_cnt == 10'h000) begin
            frm_tgl <= ~frm_tgl;
         end
      end
   end

   // Stage two: panel outputs, all aligned to one pixel slot
   always_ff @(posedge link_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         de      <= 1'b0;
         hsync_n <= 1'b1;
         vsync_n <= 1'b1;
         rgb     <= '0;
      end else begin
         de      <= pixel_req;
         hsync_n <= ~hs1;
         vsync_n <= ~vs1;
         // Porches carry zero; blank keeps timing but sends black
         if (pixel_req && !ctrl_l[1]) begin
            rgb <= pixel_in;
         end else begin
            rgb <= '0;
         end
      end
   end

   // Status levels for software
   always_ff @(posedge link_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         run_l    <= 1'b0;
         vblank_l <= 1'b1;
      end else begin
         run_l    <= running;
         vblank_l <= !(running && v_act);
      end
   end

   // Helper counters watched only by the checks below
   logic        hs_prev;
   logic        hs_fall;
   logic        vs_prev;
   logic        vs_fall;
   logic [11:0] de_len;
   logic [11:0] since_hs;
   logic [11:0] since_de;
   logic [11:0] vs_len;
   logic [9:0]  ln_cnt;

   assign hs_fall = hs_prev & ~hsync_n;
   assign vs_fall = vs_prev & ~vsync_n;

   // Run lengths and gaps; the gaps saturate so idle time cannot wrap
   always_ff @(posedge link_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         hs_prev  <= 1'b1;
         vs_prev  <= 1'b1;
         de_len   <= 12'h000;
         since_hs <= 12'h000;
         since_de <= 12'hFFF;
         vs_len   <= 12'h000;
      end else begin
         hs_prev  <= hsync_n;
         vs_prev  <= vsync_n;
         de_len   <= de ? de_len + 12'h001 : 12'h000;
         vs_len   <= vsync_n ? 12'h000 : vs_len + 12'h001;
         if (!hsync_n) begin
            since_hs <= 12'h000;
         end else if (since_hs != 12'hFFF) begin
            since_hs <= since_hs + 12'h001;
         end
         if (de) begin
            since_de <= 12'h000;
         end else if (since_de != 12'hFFF) begin
            since_de <= since_de + 12'h001;
         end
      end
   end

   // Lines since vertical sync began, first line counted as one
   always_ff @(posedge link_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         ln_cnt <= 10'h000;
      end else if (vs_fall) begin
         ln_cnt <= 10'h001;
      end else if (hs_fall && ln_cnt != 10'h000) begin
         ln_cnt <= ln_cnt + 10'h001;
      end
   end

   AST_HS_WIDTH: assert property (
      @(posedge link_clk) disable iff (!lrst_n)
      $fell(hsync_n) |-> (!hsync_n)[*8] ##1 hsync_n)
      else $error("hsync low width is not 8 clocks");

   AST_DE_RUN: assert property (
      @(posedge link_clk) disable iff (!lrst_n)
      $fell(de) |-> de_len == {1'b0, ACTIVE_WIDTH_SETTING})
      else $error("active run is not 800 pixels");

   AST_H_BACK: assert property (
      @(posedge link_clk) disable iff (!lrst_n)
      $rose(de) |-> since_hs == {1'b0, H_BACK_PORCH_SETTING})
      else $error("horizontal back porch is not 38 clocks");

   AST_H_FRONT: assert property (
      @(posedge link_clk) disable iff (!lrst_n)
      $fell(hsync_n) && since_de < {1'b0, H_TOTAL} |->
         since_de == {1'b0, H_FRONT_PORCH_SETTING})
      else $error("horizontal front porch is not 210 clocks");

   AST_VS_LINE: assert property (
      @(posedge link_clk) disable iff (!lrst_n)
      $rose(vsync_n) |-> vs_len == {1'b0, H_TOTAL})
      else $error("vsync low is not one line period");

   AST_V_WINDOW: assert property (
      @(posedge link_clk) disable iff (!lrst_n)
      $rose(de) |-> ln_cnt > V_ACT_START && ln_cnt <= V_ACT_END)
      else $error("active line outside lines 24 to 503");

   AST_V_TOTAL: assert property (
      @(posedge link_clk) disable iff (!lrst_n)
      vs_fall && ln_cnt != 10'h000 |-> ln_cnt == V_TOTAL)
      else $error("frame is not 525 lines");

   AST_FRAME_ORDER: assert property (
      @(posedge link_clk) disable iff (!lrst_n)
      $fell(vsync_n) |-> $fell(hsync_n) ##1 vsync_n == 1'b0)
      else $error("vsync does not start with a line");

   AST_DE_QUIET: assert property (
      @(posedge link_clk) disable iff (!lrst_n)
      de |-> hsync_n && vsync_n)
      else $error("data enable during a sync pulse");

   AST_RGB_IDLE: assert property (
      @(posedge link_clk) disable iff (!lrst_n)
      !de |-> rgb == '0)
      else $error("pixel data outside data enable");

   AST_APB_WAIT: assert property (
      @(posedge pclk) disable iff (!presetn)
      psel && penable && !pready |=> pready ##1 !pready)
      else $error("ready not a single cycle after one wait");

endmodule

// ==== test/ptg_panel_model.sv ====
/*
 Panel glass model: samples the panel pins on the falling edge of the
 pixel clock and measures the line and frame timing that it sees.
 Assumes the pixel clock runs free, as a TFT panel expects.
*/
`timescale 1ns/1ps
module ptg_panel_model (
   // Panel pins
   input  wire logic        pixel_clock,
   input  wire logic        hsync_n,
   input  wire logic        vsync_n,
   input  wire logic        de,
   input  wire logic [15:0] rgb,
   // Measured widths, in pixel clocks or line counts
   output logic      [11:0] hs_w,
   output logic      [11:0] bp_w,
   output logic      [11:0] act_w,
   output logic      [11:0] fp_w,
   output logic      [11:0] vs_w,
   output logic      [11:0] lead_w,
   // Count of pin states that a panel would show wrongly
   output logic      [15:0] bad
);
   logic        ph, pd, pv;  // Pin values at the previous sample
   logic        after_de;    // Last event in this line was de falling
   logic        first;       // No de yet since vsync fell
   logic [11:0] t, vt, lv;   // Run lengths and lines since vsync

   // Start as an idle panel would see its pins
   initial begin
      {ph, pv, pd, after_de, first} = 5'b11000;
      {t, vt, lv, hs_w, bp_w, act_w, fp_w, vs_w, lead_w} = '0;
      bad = 16'h0000;
   end

   // The glass samples on the falling edge only
   always @(negedge pixel_clock) begin
      ph <= hsync_n;
      pd <= de;
      pv <= vsync_n;
      t  <= (hsync_n != ph || de != pd) ? 12'h001 : t + 12'h001;
      vt <= (vsync_n != pv) ? 12'h001 : vt + 12'h001;
      // Line begins with the sync pulse
      if (ph && !hsync_n) begin
         if (after_de) fp_w <= t;
         after_de <= 1'b0;
         lv <= lv + 12'h001;
      end
      if (!ph && hsync_n) hs_w <= t;
      if (!pd && de) begin
         bp_w <= t;
         if (first) lead_w <= lv;
         first <= 1'b0;
      end
      if (pd && !de) begin
         act_w <= t;
         after_de <= 1'b1;
      end
      if (!pv && vsync_n) vs_w <= vt;
      // Frame starts on a line start, so both fall together
      if (pv && !vsync_n) begin
         lv <= 12'h001;
         first <= 1'b1;
         if (hsync_n || !ph) bad <= bad + 16'h0001;
      end
      // Blanking carries no data and no enable
      if ((!de && rgb != 0) || (de && !hsync_n)) bad <= bad + 16'h0001;
   end
endmodule

// ==== test/ptg_top_test.sv ====
/*
 Self-checking bench for the panel timing generator: register rows
 over APB, then line timing, blanking and reset by hand.
 Assumes the panel model beside it and a free-running link clock.
*/
`timescale 1ns/1ps
module ptg_top_test;
   import ptg_pkg::*;
   typedef struct {
      logic w; logic [11:0] a; logic [31:0] d, q; logic e;
   } ptg_row_s;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        link_clk, pixel_req, frame_start, pixel_clock, err;
   logic        hsync_n, vsync_n, de;
   logic [15:0] pixel_in, rgb, exp_pix, bad;
   logic [11:0] hs_w, bp_w, act_w, fp_w, vs_w, lead_w;
   int          n_errors, compares, mode, i;
   ptg_row_s    rows [10];

   ptg_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link_clk(link_clk), .pixel_in(pixel_in),
      .pixel_req(pixel_req), .frame_start(frame_start),
      .pixel_clock(pixel_clock), .hsync_n(hsync_n), .vsync_n(vsync_n),
      .de(de), .rgb(rgb));
   ptg_panel_model panel (.pixel_clock(pixel_clock), .hsync_n(hsync_n),
      .vsync_n(vsync_n), .de(de), .rgb(rgb), .hs_w(hs_w), .bp_w(bp_w),
      .act_w(act_w), .fp_w(fp_w), .vs_w(vs_w), .lead_w(lead_w),
      .bad(bad));

   // Bus clock 8 ns; link clock 48 ns with an unrelated phase
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   initial begin
      link_clk = 1'b0;
      #3;
      forever #24 link_clk = ~link_clk;
   end

   // Pixel source: a counting pattern, one word per request
   always @(posedge link_clk) begin
      if (pixel_req === 1'b1) pixel_in <= pixel_in + 16'h0001;
   end

   // Visible pixels as the panel sees them; mode 2 skips the check
   always @(negedge pixel_clock) begin
      if (de === 1'b1) begin
         if (mode < 2) chk({16'h0, rgb}, mode ? 0 : {16'h0, exp_pix},
            "pixel");
         exp_pix <= exp_pix + 16'h0001;
      end
   end

   task automatic chk(input logic [31:0] g, e, input string m);
      compares++;
      if (g !== e) begin
         $display("CHECK FAILED at %0t: %s got %h want %h", $time, m, g, e);
         n_errors++;
      end
   endtask

   // One APB transfer; holds the request until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // No limit of its own: a hung slave is caught by the watchdog
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic stop_test;
      $display("compares %0d, mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Watchdog well beyond the roughly 1.5 ms that the tests need
   initial begin
      #3_000_000;
      chk(0, 1, "watchdog");
      stop_test;
   end

   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {n_errors, compares, mode} = '0;
      pixel_in = 16'h0001;
      exp_pix = 16'h0001;
      // Idle status reads vblank set; a write returns the old value.
      // Only the blank bit is set here, so no frame is started.
      rows = '{'{0, ADDR_CTRL, 0, 0, 0}, '{0, ADDR_STATUS, 0, 2, 0},
         '{0, ADDR_FRAMES, 0, 0, 0}, '{1, ADDR_FRAMES, '1, 0, 0},
         '{0, ADDR_FRAMES, 0, 0, 0}, '{1, 12'h00C, '1, 0, 1},
         '{0, 12'h00C, 0, 0, 1}, '{1, ADDR_CTRL, 2, 0, 0},
         '{0, ADDR_CTRL, 0, 2, 0}, '{1, ADDR_CTRL, 0, 2, 0}};
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         chk(rd, rows[i].q, "read data");
         chk({31'h0, err}, {31'h0, rows[i].e}, "error flag");
      end
      $display("test registers done");
      // Enable, then follow one frame start into its first active lines
      apb(1'b1, ADDR_CTRL, 32'h0000_0001);
      i = 0;
      while (frame_start !== 1'b1 && i < 200) begin
         @(posedge link_clk);
         i++;
      end
      chk(32'(i < 200), 1, "frame start pulse");
      repeat (40) @(posedge pclk);
      apb(1'b0, ADDR_STATUS, 0);
      chk(rd, 32'h0000_0003, "status in vsync");
      apb(1'b0, ADDR_FRAMES, 0);
      chk(rd, 32'h0000_0001, "frame count");
      i = 0;
      while (de !== 1'b1 && i < 30000) begin
         @(posedge link_clk);
         i++;
      end
      chk(32'(i < 30000), 1, "first active line");
      repeat (3 * H_TOTAL) @(posedge link_clk);
      chk({31'h0, pixel_clock}, {31'h0, link_clk}, "pixel clock");
      chk(32'(hs_w), 32'(HSYNC_WIDTH_SETTING), "hsync width");
      chk(32'(bp_w), 32'(H_BACK_PORCH_SETTING), "back porch");
      chk(32'(act_w), 32'(ACTIVE_WIDTH_SETTING), "active width");
      chk(32'(fp_w), 32'(H_FRONT_PORCH_SETTING), "front porch");
      chk(32'(vs_w), 32'(H_TOTAL), "vsync width");
      chk(32'(lead_w), 32'(V_ACT_START) + 1, "lines to active");
      chk(32'(bad), 0, "blanking and sync order");
      apb(1'b0, ADDR_STATUS, 0);
      chk(rd, 32'h0000_0001, "status in active");
      $display("test timing done");
      // Blank bit: black pixels while the enable keeps marking slots
      mode = 2;
      apb(1'b1, ADDR_CTRL, 32'h0000_0003);
      repeat (2 * H_TOTAL) @(posedge link_clk);
      mode = 1;
      repeat (2 * H_TOTAL) @(posedge link_clk);
      mode = 2;
      $display("test blank done");
      // Reset in mid-frame returns the syncs, de, rgb, pixel_req, pready and prdata[15:0] to idle
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (4) @(posedge link_clk);
      chk({hsync_n, vsync_n, de, pixel_req, pready}, 32'h18, "idle pins");
      chk({rgb, prdata[15:0]}, 0, "idle data");
      @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, ADDR_CTRL, 0);
      chk(rd, 0, "control after reset");
      $display("test reset done");
      stop_test;
   end
endmodule
